// *** dbsfc_defs.svh ***
`ifndef DBSFC_DEFS_SVH
`define DBSFC_DEFS_SVH

// ****************************************************************
// Clock and oscillator timing
// ****************************************************************
`define DBSFC_CLK_HZ 100000000
`define DBSFC_F_HIGH_HZ 300000
`define DBSFC_F_LOW_HZ 200000
`define DBSFC_F_SYNC_MIN_HZ 240000
`define DBSFC_CYC_HIGH (`DBSFC_CLK_HZ / `DBSFC_F_HIGH_HZ)
`define DBSFC_CYC_LOW (`DBSFC_CLK_HZ / `DBSFC_F_LOW_HZ)
`define DBSFC_CYC_SYNC_LOSS (2 * (`DBSFC_CLK_HZ / `DBSFC_F_SYNC_MIN_HZ))

// ****************************************************************
// Switching-cycle counts
// ****************************************************************
`define DBSFC_MODE_RUN_LEN 4
`define DBSFC_SS_CYCLES 512
`define DBSFC_SS_STEPS 5
`define DBSFC_PGOOD_CYCLES 32768
`define DBSFC_UV_ARM_CYCLES 6144

// ****************************************************************
// APB register map
// ****************************************************************
`define DBSFC_REG_CTRL 8'h00
`define DBSFC_REG_STATUS 8'h04
`define DBSFC_REG_SSLEVEL 8'h08
`define DBSFC_CTRL_FORCE_FCCM 0
`define DBSFC_CTRL_FAULT_CLR 1
`define DBSFC_CTRL_RESET 32'h0000_0000

`endif

// *** dbsfc_pkg.sv ***
package dbsfc_pkg;

    // Analogue comparator flags of one rail
    typedef struct packed {
        logic duty_done;
        logic phase_low;
        logic lower_low_ack;
        logic oc_pos;
        logic oc_neg;
        logic valley_low;
        logic reverse_cur;
        logic fb_trip;
        logic over_volt;
        logic under_10;
        logic under_25;
    } dbsfc_rail_flags_t;

    // Board-level control pins and global flags
    typedef struct packed {
        logic power_off_n;
        logic rail33_enable;
        logic rail5_enable;
        logic [1:0] order_select;
        logic light_load_forbid;
        logic sync_pin;
        logic over_temp;
        logic rail5_at_5v;
        logic batt_low;
    } dbsfc_pins_t;

    typedef enum logic [1:0] {
        DBSFC_ORD_GND = 2'b00,
        DBSFC_ORD_REF = 2'b01,
        DBSFC_ORD_BIAS = 2'b10
    } dbsfc_order_t;

    typedef enum logic [1:0] {
        DBSFC_MODE_SHUTDOWN = 2'b00,
        DBSFC_MODE_STANDBY = 2'b01,
        DBSFC_MODE_RUN = 2'b10
    } dbsfc_mode_t;

    typedef enum logic [2:0] {
        DBSFC_ST_OFF = 3'b000,
        DBSFC_ST_BOOT = 3'b001,
        DBSFC_ST_HIGH = 3'b010,
        DBSFC_ST_DEAD_HL = 3'b011,
        DBSFC_ST_LOW = 3'b100,
        DBSFC_ST_DEAD_LH = 3'b101,
        DBSFC_ST_REST = 3'b110
    } dbsfc_state_t;

endpackage : dbsfc_pkg

// *** dbsfc_ctrl.sv ***
`timescale 1ns/1ns
`include "dbsfc_defs.svh"

// How it works
// - Two modulators, half a period apart
// - Upper gate on at start, off at duty
// - Lower gate waits for low switch node
// - Lower held to next start, confirmed off
// - Four low valleys enter hysteretic mode
// - Four high valleys return to fixed frequency
// - Reverse current releases lower gate early in hysteretic mode
// - Bootstrap recharge before switching resumes
// - Five volt rail feeds bias, regulator off
// - Overcurrent ends upper or lower pulse
// - 300k, 200k or external falling-edge sync
// - Over-temperature turns all gates off, mode standby
// - Overvoltage latches uppers off, lowers on
// - Power-good low on ten percent sag
// - Armed undervoltage latches both rails off
// - Faults held until toggle or battery loss
// - Shutdown, standby and run modes
// - Soft-start limit ramps over 512 cycles
// - Power-good held low 32K cycles
// - Undervoltage armed after 6144 cycles
// - Reference order watches only 3.3V rail
// - Order select sets rail start order
module dbsfc_ctrl #(
    parameter int unsigned PGOOD_CYCLES = `DBSFC_PGOOD_CYCLES,
    parameter int unsigned UV_ARM_CYCLES = `DBSFC_UV_ARM_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire dbsfc_pkg::dbsfc_pins_t pins_i,
    input wire dbsfc_pkg::dbsfc_rail_flags_t [1:0] rail_flags_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [1:0] upper_gate_o,
    output logic [1:0] lower_gate_o,
    output logic [1:0] emul_sense_en_o,
    output logic [5:0] ilim_level_o,
    output logic pgood_o,
    output logic bias_pass_o,
    output logic bias_reg_en_o,
    output logic ref_en_o,
    output logic [1:0] mode_o
);
    import dbsfc_pkg::*;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    dbsfc_pins_t pins_s1_r, pins_r;
    dbsfc_rail_flags_t [1:0] flags_s1_r, flags_r;
    dbsfc_pins_t pins_d_r;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pins_s1_r <= '0;
            pins_r <= '0;
            pins_d_r <= '0;
            flags_s1_r <= '0;
            flags_r <= '0;
        end else begin
            pins_s1_r <= pins_i;
            pins_r <= pins_s1_r;
            pins_d_r <= pins_r;
            flags_s1_r <= rail_flags_i;
            flags_r <= flags_s1_r;
        end
    end

    // ****************************************************************
    // Oscillator and sync
    // ****************************************************************
    localparam logic [9:0] CYC_HIGH = 10'(`DBSFC_CYC_HIGH);
    localparam logic [9:0] CYC_LOW = 10'(`DBSFC_CYC_LOW);
    localparam logic [9:0] CYC_LOSS = 10'(`DBSFC_CYC_SYNC_LOSS);

    logic [9:0] osc_cnt_r, osc_period, loss_cnt_r, half_cnt_r;
    logic sync_lock_r, sync_fall, tick, tick_half;

    assign sync_fall = pins_d_r.sync_pin && !pins_r.sync_pin;
    assign osc_period = pins_r.sync_pin ? CYC_HIGH : CYC_LOW;
    assign tick = sync_lock_r ? sync_fall : (osc_cnt_r >= osc_period - 10'h001);
    assign tick_half = (osc_cnt_r == half_cnt_r) && (osc_cnt_r != 10'h000);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            osc_cnt_r <= '0;
            half_cnt_r <= CYC_LOW >> 1;
        end else if (tick) begin
            osc_cnt_r <= '0;
            half_cnt_r <= sync_lock_r ? (osc_cnt_r >> 1) : (osc_period >> 1);
        end else if (osc_cnt_r != 10'h3FF) begin
            osc_cnt_r <= osc_cnt_r + 10'h001;
        end
    end

    // External clock is taken as present while falling edges keep coming
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            loss_cnt_r <= '0;
            sync_lock_r <= 1'b0;
        end else if (sync_fall) begin
            loss_cnt_r <= '0;
            sync_lock_r <= (loss_cnt_r < CYC_LOSS) && (loss_cnt_r != 10'h000);
        end else if (loss_cnt_r < CYC_LOSS) begin
            loss_cnt_r <= loss_cnt_r + 10'h001;
        end else begin
            sync_lock_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Operating mode and sequencing
    // ****************************************************************
    logic [1:0] rail_run;
    logic device_on, any_run, fault_clear, sw_clr_r, force_fccm_r;
    logic ov_lat_r, uv_lat_r, uv_armed_r;

    assign device_on = pins_r.power_off_n && !pins_r.over_temp;

    always_comb begin
        unique case (dbsfc_order_t'(pins_r.order_select))
            DBSFC_ORD_GND: begin
                rail_run[1] = pins_r.rail33_enable;
                rail_run[0] = pins_r.rail33_enable && pins_r.rail5_enable;
            end
            DBSFC_ORD_BIAS: begin
                rail_run[0] = pins_r.rail33_enable;
                rail_run[1] = pins_r.rail33_enable && pins_r.rail5_enable;
            end
            default: begin
                rail_run[0] = pins_r.rail33_enable;
                rail_run[1] = pins_r.rail5_enable;
            end
        endcase
        rail_run = device_on ? rail_run : 2'b00;
    end
    assign any_run = |rail_run;

    // ****************************************************************
    // Latched faults
    // ****************************************************************
    assign fault_clear = (pins_r.power_off_n != pins_d_r.power_off_n) ||
                         (pins_r.rail33_enable != pins_d_r.rail33_enable) ||
                         pins_r.batt_low || sw_clr_r;

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            ov_lat_r <= 1'b0;
            uv_lat_r <= 1'b0;
        end else begin
            if (any_run && (flags_r[0].over_volt || flags_r[1].over_volt)) begin
                ov_lat_r <= 1'b1;
            end else if (fault_clear) begin
                ov_lat_r <= 1'b0;
            end
            if (uv_armed_r && (flags_r[0].under_25 || flags_r[1].under_25)) begin
                uv_lat_r <= 1'b1;
            end else if (fault_clear) begin
                uv_lat_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Startup timers
    // ****************************************************************
    logic [15:0] pg_cnt_r;
    logic [12:0] uv_cnt_r;
    logic pg_done, pg_sag;

    assign pg_done = (32'(pg_cnt_r) >= PGOOD_CYCLES);

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || !any_run) begin
            pg_cnt_r <= '0;
            uv_cnt_r <= '0;
            uv_armed_r <= 1'b0;
        end else if (tick) begin
            if (!pg_done) begin
                pg_cnt_r <= pg_cnt_r + 16'h0001;
            end
            if (32'(uv_cnt_r) + 32'd1 >= UV_ARM_CYCLES) begin
                uv_armed_r <= 1'b1;
            end else begin
                uv_cnt_r <= uv_cnt_r + 13'h0001;
            end
        end
    end

    always_comb begin
        if (dbsfc_order_t'(pins_r.order_select) == DBSFC_ORD_REF) begin
            pg_sag = !rail_run[0] || flags_r[0].under_10;
        end else begin
            pg_sag = !(&rail_run) || flags_r[0].under_10 || flags_r[1].under_10;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pgood_o <= 1'b0;
            bias_pass_o <= 1'b0;
            bias_reg_en_o <= 1'b0;
            ref_en_o <= 1'b0;
            mode_o <= DBSFC_MODE_SHUTDOWN;
        end else begin
            pgood_o <= pg_done && !pg_sag && !ov_lat_r && !uv_lat_r;
            bias_pass_o <= pins_r.power_off_n && pins_r.rail5_at_5v;
            bias_reg_en_o <= pins_r.power_off_n && !pins_r.rail5_at_5v;
            ref_en_o <= pins_r.power_off_n;
            mode_o <= !pins_r.power_off_n ? DBSFC_MODE_SHUTDOWN :
                      any_run ? DBSFC_MODE_RUN : DBSFC_MODE_STANDBY;
        end
    end

    // ****************************************************************
    // Per-rail modulators
    // ****************************************************************
    logic [1:0] hyst_mode;
    logic [2:0] ss_level [1:0];

    for (genvar g = 0; g < 2; g++) begin : g_rail
        dbsfc_rail_flags_t f;
        dbsfc_state_t state_r, state_nxt;
        logic ctick, start, trip_d_r, hyst_r, upper_r, lower_r, forbid, emul_r;
        logic [2:0] run_cnt_r;
        logic [9:0] ss_cnt_r;
        logic [2:0] lvl_r;

        assign f = flags_r[g];
        assign ctick = (g == 0) ? tick : tick_half;
        assign forbid = pins_r.light_load_forbid || force_fccm_r;
        assign start = hyst_r ? (f.fb_trip && !trip_d_r) : ctick;

        // Mode change needs four agreeing cycles in a row
        always_ff @(posedge core_clk_i) begin
            if (!rstn_i || !rail_run[g] || forbid) begin
                hyst_r <= 1'b0;
                run_cnt_r <= '0;
            end else if (ctick) begin
                if (f.valley_low != hyst_r) begin
                    if (run_cnt_r == 3'(`DBSFC_MODE_RUN_LEN - 1)) begin
                        hyst_r <= f.valley_low;
                        run_cnt_r <= '0;
                    end else begin
                        run_cnt_r <= run_cnt_r + 3'h1;
                    end
                end else begin
                    run_cnt_r <= '0;
                end
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (!rstn_i || !rail_run[g]) begin
                ss_cnt_r <= '0;
                lvl_r <= '0;
            end else if (ctick && ss_cnt_r < 10'(`DBSFC_SS_CYCLES)) begin
                ss_cnt_r <= ss_cnt_r + 10'h001;
                lvl_r <= 3'((13'(ss_cnt_r + 10'h001) * 13'(`DBSFC_SS_STEPS)) >> 9);
            end
        end

        always_comb begin
            state_nxt = state_r;
            if (!rail_run[g] || ov_lat_r || uv_lat_r) begin
                state_nxt = DBSFC_ST_OFF;
            end else begin
                unique case (state_r)
                    DBSFC_ST_OFF: state_nxt = DBSFC_ST_BOOT;
                    DBSFC_ST_BOOT: if (start) state_nxt = DBSFC_ST_DEAD_LH;
                    DBSFC_ST_DEAD_LH: if (f.lower_low_ack) state_nxt = DBSFC_ST_HIGH;
                    DBSFC_ST_HIGH: begin
                        if (f.duty_done || f.oc_pos) begin
                            state_nxt = DBSFC_ST_DEAD_HL;
                        end
                    end
                    DBSFC_ST_DEAD_HL: if (f.phase_low) state_nxt = DBSFC_ST_LOW;
                    DBSFC_ST_LOW: begin
                        if (start) begin
                            state_nxt = DBSFC_ST_DEAD_LH;
                        end else if (f.oc_neg || (hyst_r && f.reverse_cur)) begin
                            state_nxt = DBSFC_ST_REST;
                        end
                    end
                    DBSFC_ST_REST: if (start) state_nxt = DBSFC_ST_DEAD_LH;
                    default: state_nxt = DBSFC_ST_OFF;
                endcase
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (!rstn_i) begin
                state_r <= DBSFC_ST_OFF;
                upper_r <= 1'b0;
                lower_r <= 1'b0;
                trip_d_r <= 1'b0;
                emul_r <= 1'b0;
            end else begin
                state_r <= state_nxt;
                trip_d_r <= f.fb_trip;
                emul_r <= rail_run[g] && !hyst_r;
                upper_r <= (state_nxt == DBSFC_ST_HIGH);
                lower_r <= (device_on && ov_lat_r) || (state_nxt == DBSFC_ST_LOW) ||
                           (state_nxt == DBSFC_ST_BOOT);
            end
        end

        assign upper_gate_o[g] = upper_r;
        assign lower_gate_o[g] = lower_r;
        assign emul_sense_en_o[g] = emul_r;
        assign ilim_level_o[g*3 +: 3] = lvl_r;
        assign hyst_mode[g] = hyst_r;
        assign ss_level[g] = lvl_r;
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    logic apb_acc;
    logic [31:0] rd_val;
    logic hit;

    assign apb_acc = psel_i && penable_i && !pready_o;

    always_comb begin
        hit = 1'b1;
        rd_val = '0;
        unique case (paddr_i)
            `DBSFC_REG_CTRL: rd_val = {31'h0, force_fccm_r};
            `DBSFC_REG_STATUS: rd_val = {22'h0, bias_pass_o, sync_lock_r, uv_armed_r, pgood_o,
                                         uv_lat_r, ov_lat_r, hyst_mode, mode_o};
            `DBSFC_REG_SSLEVEL: rd_val = {25'h0, ss_level[1], 1'b0, ss_level[0]};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            force_fccm_r <= 1'(`DBSFC_CTRL_RESET >> `DBSFC_CTRL_FORCE_FCCM);
            sw_clr_r <= 1'b0;
        end else begin
            pready_o <= apb_acc;
            pslverr_o <= apb_acc && !hit;
            prdata_o <= (apb_acc && !pwrite_i && hit) ? rd_val : 32'h0000_0000;
            sw_clr_r <= 1'b0;
            if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == `DBSFC_REG_CTRL) begin
                force_fccm_r <= pwdata_i[`DBSFC_CTRL_FORCE_FCCM];
                sw_clr_r <= pwdata_i[`DBSFC_CTRL_FAULT_CLR];
            end
        end
    end

endmodule : dbsfc_ctrl

// *** dbsfc_board_model.sv ***
`timescale 1ns/1ns
module dbsfc_board_model #(
    parameter int DUTY = 6
) (
    input wire logic core_clk_i,
    input wire logic [1:0] upper_gate_i,
    input wire logic [1:0] lower_gate_i,
    input wire dbsfc_pkg::dbsfc_rail_flags_t [1:0] extra_i,
    output dbsfc_pkg::dbsfc_rail_flags_t [1:0] flags_o
);
    import dbsfc_pkg::*;
    logic [1:0][3:0] on_cnt_r;
    logic [1:0][1:0] up_dly_r;
    logic [1:0] low_dly_r;
    // Switch node and gate feedback follow the drives with a short lag
    always_ff @(posedge core_clk_i) begin
        for (int i = 0; i < 2; i++) begin
            on_cnt_r[i] <= upper_gate_i[i] ? on_cnt_r[i] + 4'h1 : 4'h0;
            up_dly_r[i] <= {up_dly_r[i][0], upper_gate_i[i]};
        end
        low_dly_r <= lower_gate_i;
    end
    always_comb begin
        flags_o = extra_i;
        for (int i = 0; i < 2; i++) begin
            flags_o[i].duty_done = extra_i[i].duty_done | (on_cnt_r[i] >= 4'(DUTY));
            flags_o[i].phase_low = extra_i[i].phase_low | ~|{up_dly_r[i], upper_gate_i[i]};
            flags_o[i].lower_low_ack = ~(low_dly_r[i] | lower_gate_i[i]);
        end
    end
endmodule : dbsfc_board_model

// *** dbsfc_ctrl_sva.sv ***
`timescale 1ns/1ns
module dbsfc_ctrl_sva (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire dbsfc_pkg::dbsfc_pins_t pins_i,
    input wire dbsfc_pkg::dbsfc_rail_flags_t [1:0] rail_flags_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [7:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [1:0] upper_gate_o,
    input wire logic [1:0] lower_gate_o,
    input wire logic [5:0] ilim_level_o,
    input wire logic pgood_o,
    input wire logic bias_pass_o,
    input wire logic bias_reg_en_o,
    input wire logic [1:0] mode_o
);
    import dbsfc_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_no_overlap; (upper_gate_o & lower_gate_o) == 2'h0; endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");
    property p_apart; $rose(upper_gate_o[0]) |-> !$rose(upper_gate_o[1]); endproperty
    a_apart: assert property (p_apart) else $error("rails switch together");
    property p_off;
        !pins_i.power_off_n [*4] |-> mode_o == 2'h0 && upper_gate_o == 2'h0 && !pgood_o;
    endproperty
    a_off: assert property (p_off) else $error("not shut down");
    property p_hot; pins_i.over_temp [*4] |-> (upper_gate_o | lower_gate_o) == 2'h0; endproperty
    a_hot: assert property (p_hot) else $error("running while hot");
    property p_bias;
        pins_i.rail5_at_5v [*4] ##0 mode_o != 2'h0 |-> bias_pass_o && !bias_reg_en_o;
    endproperty
    a_bias: assert property (p_bias) else $error("bias source wrong");
    property p_sag; rail_flags_i[0].under_10 [*4] |-> !pgood_o; endproperty
    a_sag: assert property (p_sag) else $error("pgood high on sag");
    property p_ocp;
        rail_flags_i[0].oc_pos [*4] ##0 upper_gate_o[0] |-> ##[1:2] !upper_gate_o[0];
    endproperty
    a_ocp: assert property (p_ocp) else $error("upper pulse not cut");
    property p_ov;
        $rose(rail_flags_i[1].over_volt) && mode_o == 2'h2
            |-> ##[2:6] upper_gate_o == 2'h0 && lower_gate_o == 2'h3;
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage not latched");
    property p_ss;
        ilim_level_o[2:0] != $past(ilim_level_o[2:0]) |-> ilim_level_o[2:0] == 3'h0
            || (ilim_level_o[2:0] == $past(ilim_level_o[2:0]) + 3'h1 && ilim_level_o[2:0] <= 3'h5);
    endproperty
    a_ss: assert property (p_ss) else $error("soft-start step wrong");
    property p_apb;
        psel_i && penable_i && !pready_o
            |=> pready_o && pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08});
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer wrong");
endmodule : dbsfc_ctrl_sva

bind dbsfc_ctrl dbsfc_ctrl_sva dbsfc_ctrl_sva_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .pins_i(pins_i), .rail_flags_i(rail_flags_i), .psel_i(psel_i), .penable_i(penable_i),
    .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .upper_gate_o(upper_gate_o), .lower_gate_o(lower_gate_o), .ilim_level_o(ilim_level_o),
    .pgood_o(pgood_o), .bias_pass_o(bias_pass_o), .bias_reg_en_o(bias_reg_en_o),
    .mode_o(mode_o));

// *** dbsfc_ctrl_test.sv ***
`timescale 1ns/1ns
module dbsfc_ctrl_test;
    import dbsfc_pkg::*;
    logic clk = 1'h0;
    logic rstn, psel, pen, pwr, prdy, perr, pg, bpass, breg, refe, sync_run, e;
    dbsfc_pins_t pins;
    dbsfc_rail_flags_t [1:0] extra, flags;
    logic [7:0] padr;
    logic [31:0] pwd, prd, q;
    logic [1:0] up, lo, emul, mode;
    logic [5:0] ilim;
    int n_errors = 0;
    int total_checks = 0;
    int sc = 0;
    int n;
    always #5 clk = ~clk;
    dbsfc_ctrl #(.PGOOD_CYCLES(40), .UV_ARM_CYCLES(20)) dbsfc_ctrl_inst (
        .core_clk_i(clk), .rstn_i(rstn), .pins_i(pins), .rail_flags_i(flags),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
        .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .upper_gate_o(up),
        .lower_gate_o(lo), .emul_sense_en_o(emul), .ilim_level_o(ilim), .pgood_o(pg),
        .bias_pass_o(bpass), .bias_reg_en_o(breg), .ref_en_o(refe), .mode_o(mode));
    dbsfc_board_model dbsfc_board_model_inst (.core_clk_i(clk), .upper_gate_i(up),
        .lower_gate_i(lo), .extra_i(extra), .flags_o(flags));
    // External clock on the frequency pin, 40 core clocks a period
    always @(posedge clk) begin
        if (sync_run) begin
            sc <= (sc == 19) ? 0 : sc + 1;
            if (sc == 19) pins.sync_pin <= ~pins.sync_pin;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'h1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'h1);
        q = prd;
        e = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb
    task automatic rise(output int g);
        logic p;
        g = 0;
        do begin
            p = up[0];
            @(posedge clk);
            g++;
        end while (!(p === 1'h0 && up[0] === 1'h1) && g < 3000);
    endtask : rise
    task automatic t_apb();
        apb(1'h1, 8'h00, 32'h3);
        apb(1'h0, 8'h00, 32'h0);
        chk("ctrl", q, 32'h1);
        apb(1'h1, 8'h04, 32'hFFFF_FFFF);
        chk("ro_err", e, 1'h0);
        apb(1'h0, 8'h04, 32'h0);
        chk("stat_mode", q[1:0], DBSFC_MODE_STANDBY);
        apb(1'h0, 8'h0C, 32'h0);
        chk("unmapped", {e, q[30:0]}, 32'h8000_0000);
        apb(1'h1, 8'h00, 32'h0);
    endtask : t_apb
    task automatic t_modes();
        pins.power_off_n <= 1'h0;
        cyc(6);
        chk("mode_off", {mode, refe}, 3'h0);
        pins.power_off_n <= 1'h1;
        pins.rail5_at_5v <= 1'h1;
        cyc(6);
        chk("stby_bias", {mode, refe, bpass, breg}, 5'hE);
        pins.rail5_at_5v <= 1'h0;
        pins.rail33_enable <= 1'h1;
        cyc(6);
        chk("run", {mode, breg}, 3'h5);
    endtask : t_modes
    task automatic t_freq();
        rise(n);
        rise(n);
        chk("per_hi", n, 32'd333);
        extra[0].oc_pos <= 1'h1;
        cyc(700);
        extra[0].oc_pos <= 1'h0;
        pins.sync_pin <= 1'h0;
        rise(n);
        rise(n);
        rise(n);
        chk("per_lo", n, 32'd500);
        pins.rail33_enable <= 1'h0;
        sync_run <= 1'h1;
        cyc(400);
        chk("ss_clear", ilim[2:0], 3'h0);
    endtask : t_freq
    task automatic t_start();
        int d;
        extra[1].under_10 <= 1'h1;
        extra[0].under_25 <= 1'h1;
        pins.rail33_enable <= 1'h1;
        cyc(120);
        extra[0].under_25 <= 1'h0;
        n = 120;
        while (pg !== 1'h1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        chk("pg_time", n > 1560 && n < 1650, 1'h1);
        for (int lv = 1; lv < 6; lv++) begin
            while (ilim[2:0] !== 3'(lv) && n < 30000) begin
                @(posedge clk);
                n++;
            end
            d = (n + 20) / 40 - (lv * 512 + 4) / 5;
            chk("ss_step", d >= -1 && d <= 1, 1'h1);
        end
        apb(1'h0, 8'h04, 32'h0);
        chk("armed", q[7:5], 3'h6);
        extra[0].under_10 <= 1'h1;
        cyc(6);
        chk("sag", pg, 1'h0);
        extra[0].under_10 <= 1'h0;
    endtask : t_start
    task automatic t_hyst();
        pins.light_load_forbid <= 1'h1;
        extra[0].valley_low <= 1'h1;
        cyc(400);
        chk("forbid", emul[0], 1'h1);
        extra[0].valley_low <= 1'h0;
        cyc(120);
        pins.light_load_forbid <= 1'h0;
        extra[0].valley_low <= 1'h1;
        cyc(100);
        chk("enter_early", emul[0], 1'h1);
        cyc(110);
        chk("enter", emul[0], 1'h0);
        extra[0].fb_trip <= 1'h1;
        cyc(60);
        extra[0].reverse_cur <= 1'h1;
        cyc(6);
        chk("reverse", lo[0], 1'h0);
        extra[0].reverse_cur <= 1'h0;
        extra[0].fb_trip <= 1'h0;
        extra[0].valley_low <= 1'h0;
        cyc(100);
        chk("leave_early", emul[0], 1'h0);
        cyc(110);
        chk("leave", emul[0], 1'h1);
    endtask : t_hyst
    task automatic t_uv();
        extra[0].under_25 <= 1'h1;
        cyc(8);
        chk("uv_gates", {up, lo}, 4'h0);
        extra[0].under_25 <= 1'h0;
        apb(1'h0, 8'h04, 32'h0);
        chk("uv_held", {q[5], up, lo}, 5'h10);
        pins.rail33_enable <= 1'h0;
        cyc(6);
        pins.rail33_enable <= 1'h1;
        n = 0;
        while ((up[0] | lo[0]) !== 1'h1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk("boot", {up[0], lo[0]}, 2'h1);
    endtask : t_uv
    task automatic t_ov();
        pins.rail5_enable <= 1'h1;
        cyc(600);
        extra[1].over_volt <= 1'h1;
        cyc(8);
        extra[1].over_volt <= 1'h0;
        cyc(300);
        chk("ov_held", {up, lo}, 4'h3);
        pins.batt_low <= 1'h1;
        cyc(6);
        pins.batt_low <= 1'h0;
        apb(1'h0, 8'h04, 32'h0);
        chk("ov_clear", q[4], 1'h0);
        chk("sync_lock", q[8], 1'h1);
        pins.over_temp <= 1'h1;
        cyc(8);
        chk("hot", {up, lo}, 4'h0);
        pins.over_temp <= 1'h0;
        pins.rail5_enable <= 1'h0;
        pins.order_select <= DBSFC_ORD_GND;
        cyc(6);
        chk("order_gnd", emul, 2'h2);
        pins.order_select <= DBSFC_ORD_BIAS;
        cyc(6);
        chk("order_bias", emul, 2'h1);
    endtask : t_ov
    task automatic wrap_up();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        rstn = 1'h0;
        psel = 1'h0;
        pen = 1'h0;
        pwr = 1'h0;
        padr = 8'h00;
        pwd = 32'h0;
        pins = '0;
        pins.power_off_n = 1'h1;
        pins.sync_pin = 1'h1;
        pins.order_select = DBSFC_ORD_REF;
        extra = '0;
        sync_run = 1'h0;
        cyc(8);
        rstn <= 1'h1;
        t_apb();
        t_modes();
        t_freq();
        t_start();
        t_hyst();
        t_uv();
        t_ov();
        wrap_up();
    end
    initial begin
        #400_000;
        n_errors++;
        wrap_up();
    end
endmodule : dbsfc_ctrl_test
